// ==== aipd_axis_inputs.v ====
/*
 * Axis discrete inputs and quadrature pulse decoder for one servo axis.
 * Assumes a 250 MHz ref_clk, asynchronous low reset, pins asynchronous,
 * and a motion engine that consumes step/direction and skip pulses.
 */
// Design decisions made here: the strobed register port and the register offsets.
//
// Operation
// RL1 - Positive overtravel low blocks positive moves; high allows them.
// RL2 - Negative overtravel low blocks negative moves; high allows them.
// RL3 - Each overtravel input has an ignore bit in control.
// RL4 - Control bit selects interlock or homing decel use of third input.
// RL5 - Interlock low decelerates then halts; high resumes motion.
// RL6 - Decel switch low during homing slows feed to fixed low rate.
// RL7 - After decel switch returns high, stop at next grid mark.
// RL8 - Active skip edge abandons current block, advancing to next.
// RL9 - Control bit picks rising or falling skip edge.
// RL10 - Skip pulses of 20 us or longer are always detected.
// RL11 - Quadrature A/B pulses are an alternative motion command source.
// RL12 - Fourfold decode, one step per edge, direction by phase order.
// RL13 - Source keeps each phase at or below 100 kHz.
// RL14 - Five inputs: emergency stop, two limits, shared input, skip.
// RL15 - All inputs pass at least two synchroniser stages first.
module aipd_axis_inputs
(
    ref_clk,
    rst_b,
    estop_n,
    pos_limit_n,
    neg_limit_n,
    interlock_decel_n,
    skip_in,
    quad_phase_a,
    quad_phase_b,
    grid_mark,
    cmd_step,
    cmd_dir,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    step_out,
    dir_out,
    skip_block,
    motion_halted,
    estop_active,
    irq
);
`include "aipd_defs.vh"

    input  wire        ref_clk;
    input  wire        rst_b;
    input  wire        estop_n;
    input  wire        pos_limit_n;
    input  wire        neg_limit_n;
    input  wire        interlock_decel_n;
    input  wire        skip_in;
    input  wire        quad_phase_a;
    input  wire        quad_phase_b;
    input  wire        grid_mark;
    input  wire        cmd_step;
    input  wire        cmd_dir;
    input  wire [3:0]  reg_addr;
    input  wire [31:0] reg_wdata;
    input  wire        reg_wr;
    input  wire        reg_rd;
    output reg  [31:0] reg_rdata;
    output reg         step_out;
    output reg         dir_out;
    output reg         skip_block;
    output reg         motion_halted;
    output reg         estop_active;
    output reg         irq;

    // Any pulse longer than this is certainly past the filter
    localparam SKIP_MIN_CYC =
        (`AIPD_SKIP_MIN_NS * `AIPD_CLK_MHZ) / 1000;

    localparam [1:0] HS_IDLE = 2'd0;
    localparam [1:0] HS_FAST = 2'd1;
    localparam [1:0] HS_SLOW = 2'd2;
    localparam [1:0] HS_GRID = 2'd3;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    wire estop_s;
    wire pos_s;
    wire neg_s;
    wire ild_s;
    wire skip_s;
    wire qa_s;
    wire qb_s;
    wire grid_s;

    aipd_sync u_sy_es (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(estop_n), .level(estop_s));            // RL14
    aipd_sync u_sy_po (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(pos_limit_n), .level(pos_s));          // RL15
    aipd_sync u_sy_ne (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(neg_limit_n), .level(neg_s));          // RL15
    aipd_sync u_sy_il (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(interlock_decel_n), .level(ild_s));    // RL15
    // Idle-low pins reset low: no false edge after reset
    aipd_sync #(.RESET_LEVEL(1'b0))
        u_sy_sk (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(skip_in), .level(skip_s));             // RL15
    aipd_sync #(.RESET_LEVEL(1'b0))
        u_sy_qa (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(quad_phase_a), .level(qa_s));          // RL15
    aipd_sync #(.RESET_LEVEL(1'b0))
        u_sy_qb (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(quad_phase_b), .level(qb_s));          // RL15
    aipd_sync #(.RESET_LEVEL(1'b0))
        u_sy_gr (.ref_clk(ref_clk), .rst_b(rst_b),
                       .pin(grid_mark), .level(grid_s));

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [7:0]  ctrl_r;
    reg  [4:0]  irq_stat_r;
    reg  [4:0]  irq_mask_r;
    reg  [15:0] slow_rate_r;
    reg  [15:0] quad_count_r;
    reg  [4:0]  ev_nxt;

    wire pos_ign    = ctrl_r[`AIPD_CTRL_POS_IGN];
    wire neg_ign    = ctrl_r[`AIPD_CTRL_NEG_IGN];
    wire decel_mode = ctrl_r[`AIPD_CTRL_DECEL_MODE];
    wire skip_fall  = ctrl_r[`AIPD_CTRL_SKIP_FALL];
    wire homing     = ctrl_r[`AIPD_CTRL_HOMING];
    wire quad_en    = ctrl_r[`AIPD_CTRL_QUAD_EN];

    // Only the selected function looks at the shared input
    wire ilk_low   = !decel_mode && !ild_s;                        // RL4
    wire decel_low = decel_mode && !ild_s;                         // RL4

    wire pos_block = !pos_ign && !pos_s;                           // RL1 RL3
    wire neg_block = !neg_ign && !neg_s;                           // RL2 RL3

    // ****************************************************************
    // Skip edge detect
    // ****************************************************************
    reg  skip_d_r;
    wire skip_edge = skip_fall ? (skip_d_r && !skip_s)
                               : (!skip_d_r && skip_s);            // RL9

    // ****************************************************************
    // Quadrature decoder
    // ****************************************************************
    reg  qa_d_r;
    reg  qb_d_r;
    wire q_edge = (qa_s ^ qa_d_r) | (qb_s ^ qb_d_r);               // RL12
    // Forward when A leads B
    wire q_dir  = qa_s ^ qb_d_r;                                   // RL12

    function dir_allowed;
        input d;
        input pb;
        input nb;
        begin
            dir_allowed = d ? !pb : !nb;
        end
    endfunction

    // ****************************************************************
    // Motion gating and homing
    // ****************************************************************
    reg  [1:0]  hs_r;
    reg  [15:0] rate_cnt_r;
    reg  [3:0]  decel_cnt_r;
    reg         grid_d_r;
    reg         ild_d_r;

    wire src_step = quad_en ? (q_edge && !estop_s ? 1'b0 : q_edge)
                            : cmd_step;                            // RL11
    wire src_dir  = quad_en ? q_dir : cmd_dir;
    wire grid_rise = grid_s && !grid_d_r;
    wire ilk_halt  = ilk_low && decel_cnt_r == 4'h0;
    wire slow_tick = rate_cnt_r == 16'h0000;
    wire step_ok   = src_step && estop_s && !ilk_halt
                     && dir_allowed(src_dir, pos_block, neg_block)
                     && hs_r != HS_GRID
                     && (hs_r != HS_SLOW || slow_tick);            // RL1 RL2

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            skip_d_r     <= 1'b0;
            qa_d_r       <= 1'b0;
            qb_d_r       <= 1'b0;
            grid_d_r     <= 1'b0;
            ild_d_r      <= 1'b1;
            hs_r         <= HS_IDLE;
            rate_cnt_r   <= 16'h0000;
            decel_cnt_r  <= `AIPD_DECEL_STEPS;
            quad_count_r <= 16'h0000;
            step_out     <= 1'b0;
            dir_out      <= 1'b0;
            skip_block   <= 1'b0;
            motion_halted<= 1'b0;
            estop_active <= 1'b0;
        end
        else
        begin
            skip_d_r     <= skip_s;
            qa_d_r       <= qa_s;
            qb_d_r       <= qb_s;
            grid_d_r     <= grid_s;
            ild_d_r      <= ild_s;

            estop_active <= !estop_s;
            // Filtered level is sampled each cycle, so any pulse of
            // SKIP_MIN_CYC cycles yields exactly one edge
            skip_block   <= skip_edge;                             // RL8 RL10

            step_out     <= step_ok;
            dir_out      <= src_dir;

            if (quad_en && q_edge && !ilk_halt)
                quad_count_r <= q_dir ? quad_count_r + 16'h0001
                                      : quad_count_r - 16'h0001;   // RL12

            // Interlock: a few more steps of deceleration, then hold
            if (!ilk_low)
                decel_cnt_r <= `AIPD_DECEL_STEPS;                  // RL5
            else if (src_step && decel_cnt_r != 4'h0)
                decel_cnt_r <= decel_cnt_r - 4'h1;                 // RL5

            motion_halted <= ilk_halt || hs_r == HS_GRID;          // RL5

            if (hs_r == HS_SLOW)
                rate_cnt_r <= slow_tick ? slow_rate_r
                                        : rate_cnt_r - 16'h0001;

            case (hs_r)
                HS_IDLE:
                    if (homing && decel_mode)
                        hs_r <= HS_FAST;

                HS_FAST:
                    if (!homing)
                        hs_r <= HS_IDLE;
                    else if (decel_low)
                        hs_r <= HS_SLOW;                           // RL6

                HS_SLOW:
                    if (!homing)
                        hs_r <= HS_IDLE;
                    else if (!decel_low && grid_rise)
                        hs_r <= HS_GRID;                           // RL7

                HS_GRID:
                    if (!homing)
                        hs_r <= HS_IDLE;
                default:
                    hs_r <= HS_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Events, register port and interrupt
    // ****************************************************************
    reg  pos_d_r;
    reg  neg_d_r;
    wire pos_d_fall = pos_d_r;
    wire neg_d_fall = neg_d_r;

    always @*
    begin
        ev_nxt = 5'h00;
        ev_nxt[`AIPD_EV_SKIP]      = skip_edge;
        ev_nxt[`AIPD_EV_POS_LIM]   = !pos_s && pos_d_fall;
        ev_nxt[`AIPD_EV_NEG_LIM]   = !neg_s && neg_d_fall;
        ev_nxt[`AIPD_EV_INTERLOCK] = ilk_low && ild_d_r;
        ev_nxt[`AIPD_EV_HOME_DONE] = hs_r == HS_SLOW && !decel_low
                                     && grid_rise;
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pos_d_r     <= 1'b1;
            neg_d_r     <= 1'b1;
            ctrl_r      <= `AIPD_CTRL_RESET;
            irq_stat_r  <= 5'h00;
            irq_mask_r  <= 5'h00;
            slow_rate_r <= `AIPD_SLOW_RATE_RESET;
            reg_rdata   <= 32'h0000_0000;
            irq         <= 1'b0;
        end
        else
        begin
            pos_d_r <= pos_s;
            neg_d_r <= neg_s;

            // New events win over a write-one clear in the same cycle
            if (reg_wr && reg_addr == `AIPD_REG_IRQ_STAT)
                irq_stat_r <= (irq_stat_r & ~reg_wdata[4:0]) | ev_nxt;
            else
                irq_stat_r <= irq_stat_r | ev_nxt;

            if (reg_wr && reg_addr == `AIPD_REG_CTRL)
                ctrl_r <= reg_wdata[7:0];                          // RL3 RL4 RL9

            if (reg_wr && reg_addr == `AIPD_REG_IRQ_MASK)
                irq_mask_r <= reg_wdata[4:0];

            if (reg_wr && reg_addr == `AIPD_REG_SLOW_RATE)
                slow_rate_r <= reg_wdata[15:0];                    // RL6

            irq <= |(irq_stat_r & irq_mask_r);

            if (reg_rd)
            begin
                case (reg_addr)
                    `AIPD_REG_CTRL:
                        reg_rdata <= {24'h000000, ctrl_r};
                    `AIPD_REG_STATUS:
                        reg_rdata <= {24'h000000, hs_r, estop_s, skip_s,
                                      ild_s, neg_s, pos_s, ilk_halt};
                    `AIPD_REG_IRQ_STAT:
                        reg_rdata <= {27'h0000000, irq_stat_r};
                    `AIPD_REG_IRQ_MASK:
                        reg_rdata <= {27'h0000000, irq_mask_r};
                    `AIPD_REG_QUAD_COUNT:
                        reg_rdata <= {16'h0000, quad_count_r};
                    `AIPD_REG_SLOW_RATE:
                        reg_rdata <= {16'h0000, slow_rate_r};
                    default:
                        reg_rdata <= 32'h0000_0000;
                endcase
            end
            else
                reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // aipd_axis_inputs

// ==== aipd_defs.vh ====
/*
 * Constants of the axis input and pulse decoder: register offsets, fields,
 * reset values and timing counts.
 * Assumes a 250 MHz ref_clk and a word-wide plain register port.
 */
`ifndef AIPD_DEFS_VH
`define AIPD_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define AIPD_REG_CTRL        4'h0
`define AIPD_REG_STATUS      4'h1
`define AIPD_REG_IRQ_STAT    4'h2
`define AIPD_REG_IRQ_MASK    4'h3
`define AIPD_REG_QUAD_COUNT  4'h4
`define AIPD_REG_SLOW_RATE   4'h5

// ****************************************************************
// Control fields
// ****************************************************************
`define AIPD_CTRL_POS_IGN    0
`define AIPD_CTRL_NEG_IGN    1
`define AIPD_CTRL_DECEL_MODE 2
`define AIPD_CTRL_SKIP_FALL  3
`define AIPD_CTRL_HOMING     4
`define AIPD_CTRL_QUAD_EN    5
`define AIPD_CTRL_RESET      8'h00

// ****************************************************************
// Event bits
// ****************************************************************
`define AIPD_EV_SKIP         0
`define AIPD_EV_POS_LIM      1
`define AIPD_EV_NEG_LIM      2
`define AIPD_EV_INTERLOCK    3
`define AIPD_EV_HOME_DONE    4

// ****************************************************************
// Timing
// ****************************************************************
`define AIPD_CLK_MHZ         250
`define AIPD_SKIP_MIN_NS     20000
`define AIPD_SLOW_RATE_RESET 16'h00FF
`define AIPD_DECEL_STEPS     4'h8

`endif

// ==== aipd_sync.v ====
/*
 * Three-stage synchroniser with agreement filter for one pin.
 * Assumes the pin is asynchronous to ref_clk.
 */
module aipd_sync
(
    ref_clk,
    rst_b,
    pin,
    level
);
    parameter RESET_LEVEL = 1'b1;
    input  wire ref_clk;
    input  wire rst_b;
    input  wire pin;
    output reg  level;

    reg s1_r;
    reg s2_r;
    reg s3_r;

    // The first stage feeds the second and nothing else
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r  <= RESET_LEVEL;
            s2_r  <= RESET_LEVEL;
            s3_r  <= RESET_LEVEL;
            level <= RESET_LEVEL;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level <= s3_r;
        end
    end
endmodule // aipd_sync

// ==== aipd_axis_inputs_monitor.sv ====
/*
 * Checker for aipd_axis_inputs: limit and estop gating, skip edges,
 * read port idle value and interrupt masking.
 * Assumes it is bound into the top module and sees only its ports.
 */
`include "aipd_defs.vh"
module aipd_axis_inputs_monitor
(
    input wire        ref_clk,
    input wire        rst_b,
    input wire        estop_n,
    input wire        pos_limit_n,
    input wire        neg_limit_n,
    input wire        skip_in,
    input wire [3:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        step_out,
    input wire        dir_out,
    input wire        skip_block,
    input wire        irq
);
    // ********************
    // Helper state
    // ********************
    logic [7:0] ctrl_r;
    logic [3:0] pos_lo_r;
    logic [3:0] neg_lo_r;
    logic [3:0] stop_lo_r;
    logic [3:0] quiet_r;
    logic       skip_d_r;

    // Saturates so a long hold never wraps back to a short run
    function automatic logic [3:0] run(input logic [3:0] c, input logic b);
        return b ? c + {3'h0, c != 4'hF} : 4'h0;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
        begin
            ctrl_r    <= 8'h00;
            pos_lo_r  <= 4'h0;
            neg_lo_r  <= 4'h0;
            stop_lo_r <= 4'h0;
            quiet_r   <= 4'h0;
            skip_d_r  <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `AIPD_REG_CTRL)
                ctrl_r <= reg_wdata[7:0];
            pos_lo_r  <= run(pos_lo_r, !pos_limit_n);
            neg_lo_r  <= run(neg_lo_r, !neg_limit_n);
            stop_lo_r <= run(stop_lo_r, !estop_n);
            quiet_r   <= run(quiet_r, skip_in == skip_d_r);
            skip_d_r  <= skip_in;
        end

    // ********************
    // Assertions
    // ********************
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // Runs above 8 leave room for the synchroniser and output register
    chk_pos_block:
        assert property (pos_lo_r > 4'h8 && !ctrl_r[0] |-> !(step_out && dir_out))
        else $error("positive step past active limit");
    chk_neg_block:
        assert property (neg_lo_r > 4'h8 && !ctrl_r[1] |-> !(step_out && !dir_out))
        else $error("negative step past active limit");
    chk_estop_block:
        assert property (stop_lo_r > 4'h8 |-> !step_out)
        else $error("step while stop input low");
    chk_skip_rise:
        assert property ($rose(skip_in) && !ctrl_r[3] |-> ##[2:12] skip_block)
        else $error("rising skip edge missed");
    chk_skip_fall:
        assert property ($fell(skip_in) && ctrl_r[3] |-> ##[2:12] skip_block)
        else $error("falling skip edge missed");
    chk_skip_pulse:
        assert property (skip_block |=> !skip_block)
        else $error("skip pulse longer than a cycle");
    chk_skip_quiet:
        assert property (quiet_r > 4'hC |-> !skip_block)
        else $error("skip without an input edge");
    chk_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_irq_masked:
        assert property (reg_wr && reg_addr == `AIPD_REG_IRQ_MASK
            && reg_wdata[4:0] == 5'h00 |-> ##2 !irq)
        else $error("interrupt with all sources masked");

    cov_skip: cover property (skip_block);
    cov_neg_step: cover property (step_out && !dir_out);
    cov_irq: cover property (irq);
endmodule // aipd_axis_inputs_monitor

bind aipd_axis_inputs aipd_axis_inputs_monitor u_mon (.*);

// ==== aipd_machine.sv ====
/*
 * Machine side: contacts, stop switch, skip sensor, grid mark and an
 * A/B quadrature pulse generator.
 * Assumes the bench calls its tasks; pins move just after ref_clk edges.
 */
module aipd_machine
(
    input  wire logic ref_clk,
    output logic      estop_n,
    output logic      pos_limit_n,
    output logic      neg_limit_n,
    output logic      interlock_decel_n,
    output logic      skip_in,
    output logic      quad_phase_a,
    output logic      quad_phase_b,
    output logic      grid_mark
);
    timeunit 1ns;
    timeprecision 1ps;
    // 2.5 us between edges holds each phase at 100 kHz
    localparam int EDGE_GAP = 625;

    initial
    begin
        {estop_n, pos_limit_n, neg_limit_n, interlock_decel_n} = 4'hF;
        {skip_in, quad_phase_a, quad_phase_b, grid_mark} = 4'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic set_pin(input int k, input logic v);
        @(posedge ref_clk);
        case (k)
            0: estop_n <= v;
            1: pos_limit_n <= v;
            2: neg_limit_n <= v;
            3: interlock_decel_n <= v;
            4: skip_in <= v;
            default: grid_mark <= v;
        endcase
    endtask

    // Forward keeps A a quarter period ahead of B
    task automatic quad(input int n, input logic fwd);
        for (int i = 0; i < n; i++)
        begin
            wait_clk(EDGE_GAP);
            if ((quad_phase_a == quad_phase_b) == fwd)
                quad_phase_a <= ~quad_phase_a;
            else
                quad_phase_b <= ~quad_phase_b;
        end
        wait_clk(12);
    endtask
endmodule // aipd_machine

// ==== aipd_axis_inputs_tb.sv ====
/*
 * Self-checking bench for aipd_axis_inputs.
 * Assumes the machine model drives every pin and the checker is bound in.
 */
`include "aipd_defs.vh"
module aipd_axis_inputs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cmd_step = 1'b0;
    logic        cmd_dir = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        step_out, dir_out, skip_block, motion_halted, estop_active;
    logic        irq, estop_n, pos_limit_n, neg_limit_n, interlock_decel_n;
    logic        skip_in, quad_phase_a, quad_phase_b, grid_mark;
    int          error_cnt = 0;
    int          checks = 0;
    int          up_cnt = 0;
    int          dn_cnt = 0;
    int          skip_cnt = 0;

    aipd_axis_inputs uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .estop_n(estop_n), .pos_limit_n(pos_limit_n),
        .neg_limit_n(neg_limit_n), .interlock_decel_n(interlock_decel_n),
        .skip_in(skip_in), .quad_phase_a(quad_phase_a),
        .quad_phase_b(quad_phase_b), .grid_mark(grid_mark),
        .cmd_step(cmd_step), .cmd_dir(cmd_dir), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .step_out(step_out), .dir_out(dir_out),
        .skip_block(skip_block), .motion_halted(motion_halted),
        .estop_active(estop_active), .irq(irq));
    aipd_machine m (.ref_clk(ref_clk), .estop_n(estop_n),
        .pos_limit_n(pos_limit_n), .neg_limit_n(neg_limit_n),
        .interlock_decel_n(interlock_decel_n), .skip_in(skip_in),
        .quad_phase_a(quad_phase_a), .quad_phase_b(quad_phase_b),
        .grid_mark(grid_mark));

    initial forever #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        if (step_out === 1'b1 && dir_out === 1'b1) up_cnt++;
        if (step_out === 1'b1 && dir_out === 1'b0) dn_cnt++;
        if (skip_block === 1'b1) skip_cnt++;
    end

    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic [31:0] got, exp, input string s);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic step(input logic d, exp, input string s);
        @(posedge ref_clk);
        cmd_step <= 1'b1;
        cmd_dir <= d;
        @(posedge ref_clk);
        cmd_step <= 1'b0;
        #1 chk({step_out, step_out & dir_out}, {exp, exp & d}, s);
    endtask

    task automatic burst(input int k);
        @(posedge ref_clk);
        cmd_step <= 1'b1;
        cmd_dir <= 1'b1;
        repeat (k) @(posedge ref_clk);
        cmd_step <= 1'b0;
        m.wait_clk(4);
    endtask

    task automatic test_done();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_regs();
        logic [31:0] v;
        rd(`AIPD_REG_CTRL, v);
        chk(v, {24'h0, `AIPD_CTRL_RESET}, "ctrl reset");
        rd(`AIPD_REG_SLOW_RATE, v);
        chk(v, {16'h0, `AIPD_SLOW_RATE_RESET}, "rate reset");
        rd(4'hF, v);
        chk(v, 32'h0, "unmapped read");
        $display("t_regs done");
    endtask

    task automatic t_limit(input logic p);
        m.set_pin(p ? 1 : 2, 1'b0);
        m.wait_clk(12);
        step(p, 1'b0, "limit blocks");
        step(!p, 1'b1, "other way free");
        wr(`AIPD_REG_CTRL, p ? 32'h1 : 32'h2);
        step(p, 1'b1, "limit ignored");
        wr(`AIPD_REG_CTRL, 32'h0);
        m.set_pin(p ? 1 : 2, 1'b1);
        m.wait_clk(12);
        step(p, 1'b1, "limit released");
        $display("t_limit done");
    endtask

    task automatic t_estop();
        m.set_pin(0, 1'b0);
        m.wait_clk(12);
        chk(estop_active, 1'b1, "stop seen");
        step(1'b1, 1'b0, "stop blocks");
        m.set_pin(0, 1'b1);
        m.wait_clk(12);
        chk(estop_active, 1'b0, "stop released");
        $display("t_estop done");
    endtask

    task automatic t_ilk();
        int n;
        m.set_pin(3, 1'b0);
        m.wait_clk(12);
        n = up_cnt;
        burst(12);
        chk(up_cnt - n, `AIPD_DECEL_STEPS, "decel steps");
        chk(motion_halted, 1'b1, "halted");
        m.set_pin(3, 1'b1);
        m.wait_clk(12);
        chk(motion_halted, 1'b0, "resumed");
        step(1'b1, 1'b1, "moves again");
        wr(`AIPD_REG_CTRL, 32'h4);
        m.set_pin(3, 1'b0);
        m.wait_clk(12);
        step(1'b1, 1'b1, "no interlock");
        chk(motion_halted, 1'b0, "no halt");
        m.set_pin(3, 1'b1);
        $display("t_ilk done");
    endtask

    task automatic t_home();
        logic [31:0] v;
        int          n;
        wr(`AIPD_REG_SLOW_RATE, 32'h4);
        wr(`AIPD_REG_CTRL, 32'h14);
        m.set_pin(3, 1'b0);
        m.wait_clk(12);
        n = up_cnt;
        burst(40);
        chk((up_cnt - n) inside {[7:11]}, 1'b1, "slow feed");
        m.set_pin(3, 1'b1);
        m.wait_clk(12);
        rd(`AIPD_REG_STATUS, v);
        chk(v[7:6], 2'h2, "slow until grid");
        m.set_pin(5, 1'b1);
        m.wait_clk(4);
        m.set_pin(5, 1'b0);
        m.wait_clk(12);
        rd(`AIPD_REG_STATUS, v);
        chk(v[7:6], 2'h3, "stop at grid");
        step(1'b1, 1'b0, "no feed at grid");
        rd(`AIPD_REG_IRQ_STAT, v);
        chk(v[`AIPD_EV_HOME_DONE], 1'b1, "home done event");
        wr(`AIPD_REG_CTRL, 32'h0);
        $display("t_home done");
    endtask

    // Also walks the interrupt through raise, mask and clear
    task automatic t_skip(input logic f);
        int n;
        wr(`AIPD_REG_IRQ_STAT, 32'h1F);
        wr(`AIPD_REG_IRQ_MASK, 32'h1);
        wr(`AIPD_REG_CTRL, f ? 32'h8 : 32'h0);
        n = skip_cnt;
        m.set_pin(4, 1'b1);
        m.wait_clk(5000);
        chk(skip_cnt - n, !f, "skip on rise");
        m.set_pin(4, 1'b0);
        m.wait_clk(5000);
        chk(skip_cnt - n, 1, "one skip");
        chk(irq, 1'b1, "irq raised");
        wr(`AIPD_REG_IRQ_MASK, 32'h0);
        m.wait_clk(3);
        chk(irq, 1'b0, "irq masked");
        wr(`AIPD_REG_IRQ_MASK, 32'h1);
        m.wait_clk(3);
        chk(irq, 1'b1, "irq unmasked");
        wr(`AIPD_REG_IRQ_STAT, 32'h1);
        m.wait_clk(3);
        chk(irq, 1'b0, "irq cleared");
        $display("t_skip done");
    endtask

    task automatic t_quad();
        logic [31:0] c0;
        logic [31:0] c1;
        int          n;
        wr(`AIPD_REG_CTRL, 32'h20);
        rd(`AIPD_REG_QUAD_COUNT, c0);
        n = up_cnt;
        m.quad(8, 1'b1);
        chk(up_cnt - n, 8, "quad forward");
        rd(`AIPD_REG_QUAD_COUNT, c1);
        chk(c1[15:0], c0[15:0] + 16'h8, "count up");
        n = dn_cnt;
        m.quad(8, 1'b0);
        chk(dn_cnt - n, 8, "quad reverse");
        rd(`AIPD_REG_QUAD_COUNT, c1);
        chk(c1[15:0], c0[15:0], "count back");
        $display("t_quad done");
    endtask

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        $display("MISMATCH %0t timeout", $time);
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_regs();
        t_limit(1'b1);
        t_limit(1'b0);
        t_estop();
        t_ilk();
        t_home();
        t_skip(1'b0);
        t_skip(1'b1);
        t_quad();
        test_done();
    end
endmodule // aipd_axis_inputs_tb
